// ===== sbmfr_pkg.sv
package sbmfr_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int unsigned APB_AW = 12;
  localparam logic [9:0] IDX_QUAD = 10'h0b6;
  localparam logic [9:0] IDX_CFG = 10'h0b7;
  localparam logic [9:0] IDX_DATA = 10'h0b8;
  localparam logic [9:0] IDX_CTRL = 10'h0b9;
  localparam logic [9:0] IDX_STAT = 10'h0ba;
  localparam logic [9:0] IDX_DIV = 10'h0bb;
  localparam logic [9:0] IDX_FADDR = 10'h0bc;
  localparam logic [9:0] IDX_FCTRL = 10'h0bd;
  localparam logic [9:0] IDX_FDATA = 10'h0be;
  localparam logic [9:0] IDX_BUSSEL = 10'h0c5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_MASK = 6;
  localparam int unsigned CTRL_SEL = 5;
  localparam int unsigned CTRL_SSACT = 4;
  localparam int unsigned CTRL_OVFEN = 3;
  localparam int unsigned CTRL_EMTEN = 2;
  localparam int unsigned CTRL_CPOL = 1;
  localparam int unsigned CTRL_CPHA = 0;
  localparam int unsigned STAT_TXEMPTY = 7;
  localparam int unsigned STAT_TXFULL = 6;
  localparam int unsigned STAT_RXEMPTY = 5;
  localparam int unsigned STAT_RXFULL = 4;
  localparam int unsigned STAT_BUSY = 3;
  localparam int unsigned STAT_IRQ = 2;
  localparam int unsigned STAT_FBUSY = 1;
  localparam int unsigned BUSSEL_BIT = 7;
  localparam int unsigned CFG_ADDR32 = 5;
  localparam int unsigned FCTRL_START = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h1f;
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [31:0] FADDR_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Flash commands, phase lengths, lanes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NORMAL = 8'h03;
  localparam logic [7:0] CMD_FAST = 8'h0b;
  localparam logic [7:0] CMD_FASTER = 8'h1b;
  localparam logic [7:0] CMD_DUAL = 8'h3b;
  localparam logic [7:0] CMD_QUAD = 8'h6b;
  localparam logic [7:0] CMD_QUADIO = 8'heb;
  localparam logic [5:0] DUM_NONE = 6'h00;
  localparam logic [5:0] DUM_8 = 6'h08;
  localparam logic [5:0] DUM_16 = 6'h10;
  localparam logic [5:0] DUM_QIO = 6'h06;
  localparam logic [5:0] ADDR_SHORT = 6'h18;
  localparam logic [5:0] ADDR_LONG = 6'h20;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_BYTE = 6'b000010,
    S_CMD = 6'b000100,
    S_ADDR = 6'b001000,
    S_DUMMY = 6'b010000,
    S_DATA = 6'b100000
  } sbmfr_state_t;

endpackage

// ===== sbmfr_fifo.sv
module sbmfr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic clear, // Empty the FIFO
  input wire logic push, // Write one entry
  input wire logic [WIDTH-1:0] wdata, // Entry written
  input wire logic pop, // Remove oldest entry
  output logic [WIDTH-1:0] rdata, // Entry at the read pointer (the newest after a write when full)
  output logic empty, // No entries
  output logic full // All entries used
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = DEPTH[AW:0];

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] fifo_read_pointer_ff;
  logic [AW:0] cnt_ff;
  wire do_pop = pop && (cnt_ff != '0);
  // Full write lands on the oldest slot; read pointer stays, so the newest goes next
  wire drop_old = push && !do_pop && (cnt_ff == CNT_FULL); // RULE9

  assign rdata = mem[fifo_read_pointer_ff];
  assign empty = (cnt_ff == '0);
  assign full = (cnt_ff == CNT_FULL);

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_ff] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= '0;
      fifo_read_pointer_ff <= '0;
      cnt_ff <= '0;
    end else if (clear) begin
      wr_ptr_ff <= '0;
      fifo_read_pointer_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_pop) begin
        fifo_read_pointer_ff <= fifo_read_pointer_ff + 1'b1;
      end
      if (push && !do_pop && !drop_old) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (do_pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ===== sbmfr_top.sv
// Notes on behaviour
// RULE1: Each byte shifted out samples one byte in during the same transfer.
// RULE2: Clock polarity and phase bits pick one of four transfer modes.
// RULE3: Outgoing bit is placed on the output line before its sampling edge.
// RULE4: Each data port write pushes a byte into the 16-entry transmit FIFO.
// RULE5: While select-active is set and transmit FIFO holds data, bytes go out automatically.
// RULE6: Each finished byte transfer pushes the received byte into the receive FIFO.
// RULE7: Host queues one dummy byte per byte it wants to receive.
// RULE8: Reading the data port returns and removes the oldest receive entry.
// RULE9: Both FIFOs are circular; writing when full overwrites the oldest entry.
// RULE10: Clearing select-active resets both FIFOs.
// RULE11: Host drains receive FIFO every 16 bytes or does aligning dummy reads.
// RULE12: Bus-select bit 7 routes the master to serial bus 0 or bus 1.
// RULE13: Control register: zero, mask, select choice, active, ovf en, empty en, polarity, phase.
// RULE14: Status shows FIFO state and interrupt flag; writing bit 2 clears the flag.
// RULE15: Divisor register sets serial clock as a division of the core clock.
// RULE16: Config 000x: command 03h, no dummy cycles, single-line data.
// RULE17: Config 010x: command 0Bh, 8 dummy cycles, single-line data.
// RULE18: Config 1x0x: command 1Bh, 16 dummy cycles, single-line data.
// RULE19: Config xx10: command 3Bh, 8 dummy cycles, data on two lines.
// RULE20: Quad select 01 gives 6Bh, 10 gives EBh; address and data on four lines.
// RULE21: Config bit 5 picks a 24 or 32 cycle address phase (on four lines the code takes 6 or 8 cycles).
// RULE22: Host writes two extra index bytes for special-range character codes.
// RULE23: Serial clock idles at polarity level; select follows select-active (the code also asserts select while a flash read is busy).
//
// The APB interface to the registers is this design's own decision.
module sbmfr_top
  import sbmfr_pkg::*;
(
  input wire logic pclk, // Core clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [APB_AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  output logic bus0_serial_clock, // Bus 0 clock
  output logic [3:0] bus0_line_out, // Bus 0 lines 3..0 drive value
  output logic [3:0] bus0_line_oe, // Bus 0 lines drive enable
  input wire logic [3:0] bus0_line_in, // Bus 0 lines level
  output logic bus1_serial_clock, // Bus 1 clock
  output logic [3:0] bus1_line_out, // Bus 1 lines drive value
  output logic [3:0] bus1_line_oe, // Bus 1 lines drive enable
  input wire logic [3:0] bus1_line_in, // Bus 1 lines level
  output logic select0_n, // Slave select 0, low
  output logic select1_n // Slave select 1, low
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] cycles_for(input logic [5:0] bits, input logic [2:0] lanes);
    logic [5:0] c;
    c = bits;
    if (lanes == LANE4) begin
      c = bits >> 2;
    end else if (lanes == LANE2) begin
      c = bits >> 1;
    end
    return c;
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic [2:0] lanes,
                                          input logic [3:0] ln);
    logic [7:0] r;
    r = {sr[6:0], ln[1]};
    if (lanes == LANE4) begin
      r = {sr[3:0], ln[3:0]};
    end else if (lanes == LANE2) begin
      r = {sr[5:0], ln[1:0]};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers and signals
  // ----------------------------------------------------------------
  logic [7:0] quad_ff, cfg_ff, ctrl_ff, div_ff, bussel_ff, fdata_ff;
  logic [31:0] faddr_ff;
  logic freq_ff, irq_ff, pready_ff, rd_ok_ff;
  logic [7:0] sync1_ff, sync2_ff;
  sbmfr_state_t state_ff, nxt_state;
  logic [7:0] divcnt_ff;
  logic sck_ff, first_ff, drive_ff;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [2:0] lanes_ff, nxt_lanes;
  logic nxt_drive, load;
  logic [31:0] osr_ff, nxt_osr;
  logic [7:0] isr_ff;
  logic tx_empty, tx_full, rx_empty, rx_full;
  logic [7:0] tx_head, rx_head;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire [9:0] idx = paddr[APB_AW-1:2];
  wire h_quad = (idx == IDX_QUAD);
  wire h_cfg = (idx == IDX_CFG);
  wire h_data = (idx == IDX_DATA);
  wire h_ctrl = (idx == IDX_CTRL);
  wire h_stat = (idx == IDX_STAT);
  wire h_div = (idx == IDX_DIV);
  wire h_faddr = (idx == IDX_FADDR);
  wire h_fctrl = (idx == IDX_FCTRL);
  wire h_fdata = (idx == IDX_FDATA);
  wire h_bussel = (idx == IDX_BUSSEL);
  wire mapped = h_quad | h_cfg | h_data | h_ctrl | h_stat | h_div | h_faddr | h_fctrl | h_fdata | h_bussel;
  wire setup = psel && !penable;
  wire acc = psel && penable && pready_ff;
  wire wr = acc && pwrite && mapped;
  wire rd = acc && !pwrite;
  wire ss_active = ctrl_ff[CTRL_SSACT];
  wire cpol = ctrl_ff[CTRL_CPOL];
  wire cpha = ctrl_ff[CTRL_CPHA];
  wire busy = (state_ff != S_IDLE);
  wire flash_busy = freq_ff || (busy && (state_ff != S_BYTE));
  wire [7:0] stat_val = {tx_empty, tx_full, rx_empty, rx_full, busy, irq_ff, flash_busy, 1'b0};

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0;
    if (h_quad) begin
      rd_val[7:0] = quad_ff;
    end else if (h_cfg) begin
      rd_val[7:0] = cfg_ff;
    end else if (h_data) begin
      rd_val[7:0] = rx_head; // RULE8
    end else if (h_ctrl) begin
      rd_val[7:0] = {1'b0, ctrl_ff[6:0]}; // RULE13
    end else if (h_stat) begin
      rd_val[7:0] = stat_val; // RULE14
    end else if (h_div) begin
      rd_val[7:0] = div_ff;
    end else if (h_faddr) begin
      rd_val = faddr_ff;
    end else if (h_fctrl) begin
      rd_val[FCTRL_START] = flash_busy;
    end else if (h_fdata) begin
      rd_val[7:0] = fdata_ff;
    end else if (h_bussel) begin
      rd_val[7:0] = bussel_ff;
    end
  end

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  wire tx_push = wr && h_data; // RULE4
  wire rx_pop = rd && h_data && rd_ok_ff; // RULE8
  wire fifo_clr = !ss_active; // RULE10
  wire start_byte = (state_ff == S_IDLE) && !freq_ff && ss_active && !tx_empty; // RULE5
  logic rx_push;
  logic [7:0] in_next;

  sbmfr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
    .pclk(pclk), .presetn(presetn), .clear(fifo_clr), .push(tx_push), .wdata(pwdata[7:0]),
    .pop(start_byte), .rdata(tx_head), .empty(tx_empty), .full(tx_full)
  ); // RULE9

  sbmfr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxf (
    .pclk(pclk), .presetn(presetn), .clear(fifo_clr), .push(rx_push), .wdata(in_next),
    .pop(rx_pop), .rdata(rx_head), .empty(rx_empty), .full(rx_full)
  ); // RULE9

  // ----------------------------------------------------------------
  // Flash command decode
  // ----------------------------------------------------------------
  wire q6b = (quad_ff[7:6] == 2'b01);
  wire qeb = (quad_ff[7:6] == 2'b10);
  wire dual = (cfg_ff[1:0] == 2'b10);
  wire f16 = cfg_ff[3] && !cfg_ff[1];
  wire f8 = (cfg_ff[3:2] == 2'b01) && !cfg_ff[1];
  wire [7:0] f_cmd = q6b ? CMD_QUAD : qeb ? CMD_QUADIO : dual ? CMD_DUAL : // RULE20 RULE19
                     f16 ? CMD_FASTER : f8 ? CMD_FAST : CMD_NORMAL; // RULE18 RULE17 RULE16
  wire [5:0] f_dummy = q6b ? DUM_8 : qeb ? DUM_QIO : dual ? DUM_8 :
                       f16 ? DUM_16 : f8 ? DUM_8 : DUM_NONE; // RULE16 RULE17 RULE18 RULE19
  wire [2:0] a_lanes = (q6b || qeb) ? LANE4 : LANE1; // RULE20
  wire [2:0] d_lanes = (q6b || qeb) ? LANE4 : dual ? LANE2 : LANE1; // RULE19
  wire [5:0] a_bits = cfg_ff[CFG_ADDR32] ? ADDR_LONG : ADDR_SHORT; // RULE21
  wire [31:0] a_word = cfg_ff[CFG_ADDR32] ? faddr_ff : {faddr_ff[23:0], 8'h00};

  // ----------------------------------------------------------------
  // Serial engine timing
  // ----------------------------------------------------------------
  wire tick = busy && (divcnt_ff == 8'h00); // RULE15
  wire cpha_eff = (state_ff == S_BYTE) ? cpha : 1'b0;
  wire lead = tick && (sck_ff == cpol); // RULE2
  wire trail = tick && (sck_ff != cpol);
  wire seg_done = trail && (cnt_ff == 6'h01);
  wire do_sample = cpha_eff ? trail : lead; // RULE2
  wire do_shift = cpha_eff ? (lead && !first_ff) : (trail && !seg_done); // RULE3
  wire [3:0] lanes_in = bussel_ff[BUSSEL_BIT] ? sync2_ff[7:4] : sync2_ff[3:0];
  assign in_next = do_sample ? shift_in(isr_ff, lanes_ff, lanes_in) : isr_ff; // RULE1
  assign rx_push = seg_done && (state_ff == S_BYTE); // RULE6

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_lanes = lanes_ff;
    nxt_drive = drive_ff;
    nxt_osr = do_shift ? (osr_ff << lanes_ff) : osr_ff;
    load = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (freq_ff) begin
          nxt_state = S_CMD;
          nxt_cnt = BYTE_BITS;
          nxt_lanes = LANE1;
          nxt_drive = 1'b1;
          nxt_osr = {f_cmd, 24'h0};
          load = 1'b1;
        end else if (start_byte) begin
          nxt_state = S_BYTE;
          nxt_cnt = BYTE_BITS;
          nxt_lanes = LANE1;
          nxt_drive = 1'b1;
          nxt_osr = {tx_head, 24'h0}; // RULE3
          load = 1'b1;
        end
      end
      S_BYTE: begin
        if (!ss_active || seg_done) begin
          nxt_state = S_IDLE;
          nxt_drive = 1'b0;
        end
      end
      S_CMD: begin
        if (seg_done) begin
          nxt_state = S_ADDR;
          nxt_lanes = a_lanes;
          nxt_cnt = cycles_for(a_bits, a_lanes); // RULE21
          nxt_osr = a_word;
          load = 1'b1;
        end
      end
      S_ADDR: begin
        if (seg_done) begin
          nxt_drive = 1'b0;
          load = 1'b1;
          if (f_dummy != DUM_NONE) begin
            nxt_state = S_DUMMY;
            nxt_cnt = f_dummy;
          end else begin
            nxt_state = S_DATA;
            nxt_lanes = d_lanes;
            nxt_cnt = cycles_for(BYTE_BITS, d_lanes);
          end
        end
      end
      S_DUMMY: begin
        if (seg_done) begin
          nxt_state = S_DATA;
          nxt_lanes = d_lanes;
          nxt_cnt = cycles_for(BYTE_BITS, d_lanes);
          load = 1'b1;
        end
      end
      S_DATA: begin
        if (seg_done) begin
          nxt_state = S_IDLE;
        end
      end
      default: begin
        nxt_state = S_IDLE;
        nxt_drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      cnt_ff <= 6'h00;
      lanes_ff <= LANE1;
      drive_ff <= 1'b0;
      osr_ff <= 32'h0;
      isr_ff <= 8'h00;
      first_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= (trail && !seg_done) ? cnt_ff - 6'h01 : nxt_cnt;
      lanes_ff <= nxt_lanes;
      drive_ff <= nxt_drive;
      osr_ff <= nxt_osr;
      isr_ff <= in_next;
      first_ff <= load ? 1'b1 : (lead ? 1'b0 : first_ff);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divcnt_ff <= DIV_RST;
      sck_ff <= 1'b0;
    end else begin
      divcnt_ff <= (!busy || tick) ? div_ff : divcnt_ff - 8'h01; // RULE15
      sck_ff <= busy ? (sck_ff ^ tick) : cpol; // RULE23
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  wire irq_set = (rx_push && tx_empty && ctrl_ff[CTRL_EMTEN]) || (tx_push && tx_full && ctrl_ff[CTRL_OVFEN]);
  wire irq_clr = wr && h_stat && pwdata[STAT_IRQ]; // RULE14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_ff <= REG8_RST;
      cfg_ff <= REG8_RST;
      ctrl_ff <= CTRL_RST;
      div_ff <= DIV_RST;
      bussel_ff <= REG8_RST;
      faddr_ff <= FADDR_RST;
      freq_ff <= 1'b0;
      fdata_ff <= REG8_RST;
      irq_ff <= 1'b0;
    end else begin
      if (wr && h_quad) quad_ff <= pwdata[7:0];
      if (wr && h_cfg) cfg_ff <= pwdata[7:0];
      if (wr && h_ctrl) ctrl_ff <= {1'b0, pwdata[6:0]}; // RULE13
      if (wr && h_div) div_ff <= pwdata[7:0];
      if (wr && h_bussel) bussel_ff <= pwdata[7:0]; // RULE12
      if (wr && h_faddr) faddr_ff <= pwdata;
      if (wr && h_fctrl && pwdata[FCTRL_START]) begin
        freq_ff <= 1'b1;
      end else if (state_ff == S_IDLE) begin
        freq_ff <= 1'b0;
      end
      if (seg_done && (state_ff == S_DATA)) fdata_ff <= in_next;
      irq_ff <= irq_set ? 1'b1 : (irq_clr ? 1'b0 : irq_ff); // RULE14
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pready_ff <= 1'b0;
      pslverr <= 1'b0;
      rd_ok_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr <= setup && !mapped;
      rd_ok_ff <= setup && !rx_empty;
      if (setup) prdata <= rd_val;
    end
  end
  assign pready = pready_ff;

  // ----------------------------------------------------------------
  // Pin sync and registered pin outputs
  // ----------------------------------------------------------------
  wire [3:0] lane_out = (lanes_ff == LANE4) ? osr_ff[31:28] :
                        (lanes_ff == LANE2) ? {2'b00, osr_ff[31:30]} : {3'b000, osr_ff[31]};
  wire [3:0] lane_oe = !drive_ff ? 4'h0 : (lanes_ff == LANE4) ? 4'hf : (lanes_ff == LANE2) ? 4'h3 : 4'h1;
  wire sel_on = ss_active || flash_busy; // RULE23
  wire on1 = bussel_ff[BUSSEL_BIT]; // RULE12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
      bus0_serial_clock <= 1'b0;
      bus1_serial_clock <= 1'b0;
      bus0_line_out <= 4'h0;
      bus1_line_out <= 4'h0;
      bus0_line_oe <= 4'h0;
      bus1_line_oe <= 4'h0;
      select0_n <= 1'b1;
      select1_n <= 1'b1;
    end else begin
      sync1_ff <= {bus1_line_in, bus0_line_in};
      sync2_ff <= sync1_ff;
      bus0_serial_clock <= on1 ? cpol : sck_ff;
      bus1_serial_clock <= on1 ? sck_ff : cpol;
      bus0_line_out <= on1 ? 4'h0 : lane_out;
      bus1_line_out <= on1 ? lane_out : 4'h0;
      bus0_line_oe <= on1 ? 4'h0 : lane_oe;
      bus1_line_oe <= on1 ? lane_oe : 4'h0;
      select0_n <= !(sel_on && !ctrl_ff[CTRL_SEL]); // RULE23
      select1_n <= !(sel_on && ctrl_ff[CTRL_SEL]);
    end
  end
endmodule

// ===== sbmfr_props.sv
module sbmfr_props
  import sbmfr_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic [APB_AW-1:0] paddr, // Address
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic bus0_serial_clock, // Bus 0 clock
  input wire logic [3:0] bus0_line_oe, // Bus 0 enables
  input wire logic [3:0] bus1_line_oe, // Bus 1 enables
  input wire logic select0_n, // Select 0
  input wire logic select1_n // Select 1
);
  wire setup = psel && !penable;
  wire hit = (paddr[11:2] >= IDX_QUAD && paddr[11:2] <= IDX_FDATA) || paddr[11:2] == IDX_BUSSEL;
  wire idle = select0_n && select1_n;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  ready_in_time_a: assert property (setup |=> pready && penable)
    else $error("ready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  unmapped_err_a: assert property (setup && !hit |=> pslverr)
    else $error("no error");
  mapped_ok_a: assert property (setup && hit |=> !pslverr)
    else $error("false error");
  one_select_a: assert property (select0_n || select1_n)
    else $error("two selects");
  one_bus_a: assert property (!(|bus0_line_oe && |bus1_line_oe))
    else $error("two buses");
  quiet_idle_a: assert property (idle [*2] |-> bus0_line_oe == 4'h0 && bus1_line_oe == 4'h0)
    else $error("drive while idle");
  sck_half_a: assert property ($changed(bus0_serial_clock) && !select0_n |=> $stable(bus0_serial_clock) [*4])
    else $error("clock too fast");
  cover property (pslverr);
  cover property (!select0_n ##1 select0_n);
  cover property ($changed(bus0_serial_clock) && !select0_n);
endmodule
bind sbmfr_top sbmfr_props u_props (.pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr,
  .bus0_serial_clock, .bus0_line_oe, .bus1_line_oe, .select0_n, .select1_n);

// ===== sbmfr_slave.sv
module sbmfr_slave #(
  parameter logic [7:0] FIRST = 8'ha5
) (
  input wire logic sck, // Serial clock
  input wire logic sel_n, // Select, low
  input wire logic cpol, // Idle clock level
  input wire logic cpha, // Sample on trailing edge
  input wire logic [3:0] line_out, // Master drive values
  input wire logic [3:0] line_oe, // Master drive enables
  output logic [3:0] line_in // Line levels
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shin = 8'h00;
  logic [7:0] shout = FIRST;
  logic [3:0] cnt = 4'h0;
  logic junk = 1'b0;
  // Released lines wander
  assign line_in = (line_oe & line_out) | (~line_oe & {junk, junk, sel_n ? junk : shout[7], junk});
  always #7 junk = ~junk;
  always @(negedge sel_n) begin
    cnt = 4'h0;
    shout = FIRST;
  end
  // Reply to each byte is the inverse of the one before
  always @(sck) begin
    if (!sel_n && ((sck != cpol) ^ cpha)) begin
      shin = {shin[6:0], line_out[0]};
      cnt = cnt + 4'h1;
    end else if (!sel_n && cnt == 4'h8) begin
      shout = ~shin;
      cnt = 4'h0;
    end else if (!sel_n && cnt != 4'h0) begin
      shout = shout << 1;
    end
  end
endmodule

// ===== test_serial_bus_master_flash_reader.sv
module test_serial_bus_master_flash_reader
  import sbmfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic c; logic e; logic [31:0] x;} sbmfr_note_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sck0, sck1, sel0_n, sel1_n;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r, seed = 32'd6771;
  logic [3:0] out0, oe0, in0, out1, oe1, in1 = 4'h0;
  logic [1:0] mode = 2'h0;
  logic [7:0] b [18];
  int error_cnt = 0, comparisons = 0, i, m;
  sbmfr_note_t q[$], nt;
  sbmfr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus0_serial_clock(sck0),
    .bus0_line_out(out0), .bus0_line_oe(oe0), .bus0_line_in(in0), .bus1_serial_clock(sck1), .bus1_line_out(out1),
    .bus1_line_oe(oe1), .bus1_line_in(in1), .select0_n(sel0_n), .select1_n(sel1_n));
  sbmfr_slave #(.FIRST(8'ha5)) peer (.sck(sck0), .sel_n(sel0_n), .cpol(mode[1]), .cpha(mode[0]),
    .line_out(out0), .line_oe(oe0), .line_in(in0));
  initial forever #10 pclk = ~pclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] x, input logic [31:0] d, input logic c, input logic [31:0] e);
    int n;
    n = 0;
    q.push_back({c, !((x >= IDX_QUAD && x <= IDX_FDATA) || x == IDX_BUSSEL), e});
    seed = xs(seed);
    in1 <= seed[3:0];
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {x, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    if (pready !== 1'b1) begin
      error_cnt++;
      conclude;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic settle(input int s, input logic v);
    int k;
    k = 0;
    do begin
      apb(0, IDX_STAT, 0, 0, 0);
      k++;
    end while (k < 1000 && r[s] !== v);
    if (r[s] !== v) begin
      error_cnt++;
      conclude;
    end
  endtask
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) cmp(1, 0);
      else begin
        nt = q.pop_front();
        cmp(pslverr, nt.e);
        if (nt.c) cmp(prdata, nt.x);
      end
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_CTRL, 0, 1, {24'h0, CTRL_RST});
    apb(0, IDX_DIV, 0, 1, {24'h0, DIV_RST});
    apb(0, IDX_STAT, 0, 1, 32'ha0);
    apb(0, 10'h0c0, 0, 1, 0);
    apb(1, 10'h000, 32'h5, 0, 0);
    apb(1, IDX_DIV, 4, 0, 0);
    apb(0, IDX_DIV, 0, 1, 4);
    for (i = 0; i < 2; i++) begin
      seed = xs(seed);
      m = seed & (i ? 32'h2f : 32'hc0);
      apb(1, IDX_QUAD + 10'(i), m, 0, 0);
      apb(0, IDX_QUAD + 10'(i), 0, 1, m);
    end
    apb(1, IDX_BUSSEL, 0, 0, 0);
    apb(0, IDX_BUSSEL, 0, 1, 0);
    apb(1, IDX_QUAD, 0, 0, 0);
    for (i = 0; i < 2; i++) begin
      seed = xs(seed);
      m = seed;
      apb(1, IDX_CFG, i ? 32'h20 : 32'h0, 0, 0);
      apb(1, IDX_FADDR, m, 0, 0);
      apb(1, IDX_FCTRL, 32'h1, 0, 0);
      settle(STAT_FBUSY, 0);
      apb(0, IDX_FDATA, 0, 1, {24'h0, ~m[7:0]});
    end
    for (m = 0; m < 4; m++) begin
      mode = m[1:0];
      apb(1, IDX_CTRL, 8'h04 | m, 0, 0);
      apb(1, IDX_CTRL, 8'h14 | m, 0, 0);
      for (i = 0; i < 3; i++) begin
        seed = xs(seed);
        b[i] = seed[7:0];
        apb(1, IDX_DATA, {24'h0, b[i]}, 0, 0);
      end
      settle(STAT_TXEMPTY, 1);
      settle(STAT_BUSY, 0);
      apb(0, IDX_STAT, 0, 1, 32'h84);
      apb(1, IDX_STAT, 32'h4, 0, 0);
      apb(0, IDX_STAT, 0, 1, 32'h80);
      apb(0, IDX_DATA, 0, 1, 32'ha5);
      apb(0, IDX_DATA, 0, 1, {24'h0, ~b[0]});
      apb(0, IDX_DATA, 0, 1, {24'h0, ~b[1]});
      apb(1, IDX_CTRL, 8'h04 | m, 0, 0);
    end
    mode = 2'h0;
    apb(1, IDX_CTRL, 0, 0, 0);
    apb(1, IDX_CTRL, 32'h10, 0, 0);
    for (i = 0; i < 18; i++) begin
      seed = xs(seed);
      b[i] = seed[7:0];
      apb(1, IDX_DATA, {24'h0, b[i]}, 0, 0);
    end
    apb(0, IDX_STAT, 0, 1, 32'h68);
    settle(STAT_RXEMPTY, 0);
    apb(0, IDX_DATA, 0, 1, 32'ha5);
    settle(STAT_TXEMPTY, 1);
    settle(STAT_BUSY, 0);
    apb(0, IDX_DATA, 0, 1, {24'h0, ~b[0]});
    apb(0, IDX_DATA, 0, 1, {24'h0, ~b[17]});
    apb(1, IDX_CTRL, 0, 0, 0);
    apb(0, IDX_STAT, 0, 1, 32'ha0);
    conclude;
  end
endmodule
